// >>> hw/carrier_timer_defs.svh
// register offsets, field positions and reset values of the carrier counter/timer
`ifndef CARRIER_TIMER_DEFS_SVH
`define CARRIER_TIMER_DEFS_SVH
`define OFS_NARROW_CTRL 6'h00
`define OFS_SHARED_CTRL 6'h04
`define OFS_WIDE_CTRL 6'h08
`define OFS_SYNC_CTRL 6'h0C
`define OFS_NARROW_LOW_HOLD 6'h10
`define OFS_NARROW_HIGH_HOLD 6'h14
`define OFS_WIDE_HOLD_LOWER 6'h18
`define OFS_WIDE_HOLD_UPPER 6'h1C
`define OFS_WIDE_CAP_LOWER 6'h20
`define OFS_WIDE_CAP_UPPER 6'h24
`define OFS_NARROW_CAP_LOW 6'h28
`define OFS_NARROW_CAP_HIGH 6'h2C
`define BIT_EN 7
`define BIT_SINGLE 6
`define BIT_TOUT 5
`define BIT_CLK_HI 4
`define BIT_CLK_LO 3
`define BIT_CAP_IE 2
`define BIT_TOUT_IE 1
`define BIT_PIN_SEL 0
`define BIT_MODE 7
`define BIT_SEL 6
`define BIT_FN_HI 5
`define BIT_FN_LO 4
`define BIT_SUB_HI 3
`define BIT_SUB_LO 2
`define BIT_INIT8 1
`define BIT_INIT16 0
`define BIT_SYNC_WIDE_EN 7
`define BIT_SYNC_NARROW_EN 6
`define BIT_SYNC_MODE 5
`define SYNC_RESERVED 5'h1F
`define CTRL_RESET 8'h00
`define HOLD_RESET 8'h00
`define NARROW_FULL 8'hFF
`define WIDE_FULL 16'hFFFF
`define FILTER_SHORT 4'h4
`define FILTER_LONG 4'h8
`endif

// >>> hw/carrier_timer_pkg.sv
// types shared by the carrier counter/timer
package carrier_timer_pkg;
	typedef enum logic [1:0] {SUB_NORMAL, SUB_PINGPONG, SUB_FORCE_LOW, SUB_FORCE_HIGH} submode_type;
	typedef enum logic [1:0] {FN_AND, FN_OR, FN_NOR, FN_NAND} combine_type;
	typedef enum logic [1:0] {EDGE_FALL, EDGE_RISE, EDGE_BOTH, EDGE_NONE} edge_type;
endpackage

// >>> hw/dual_carrier_counter_timer.sv
// paired 8/16-bit carrier counter/timer with wishbone register access
// Overview of operation
// - mode bit 0 selects transmit, 1 selects demodulation for both counters
// - select bit routes shared pin in transmit, picks input pin in demodulation
// - transmit combined output is AND, OR, NOR or NAND of both outputs
// - edge detector pulses on chosen edges after glitch filter of chosen width
// - submode 01 makes single-pass ends ping-pong; 10 forces wide output low, 11 high
// - narrow output starts at initial level, holds inverse while disabled
// - wide output likewise, only in normal or ping-pong submode
// - demodulation sets rise and fall flags; writing 1 clears them
// - transmit wide counter reloads at terminal count, or stops if single-pass
// - demodulation wide counter starts on first edge, captures each later edge; single-pass accepts only the first
// - wide timeout flag sets at terminal count; write 1 clears
// - clock field picks full, half, quarter or eighth count rate
// - wide control holds capture and timeout enables and pin select
// - sync register mirrors both enables, sync bit, reserved bits read ones
// - narrow enable loads low hold for level 0, else high hold
// - narrow single-pass counts to zero, stops, toggles, flags, interrupts
// - narrow modulo-N toggles and reloads each end, flags once per cycle
// - holds take effect at next load; zero wraps through FF without timeout
// - narrow demodulation starts on first edge, captures complement, reloads FF
// - narrow demodulation timeout sets flag and continues from FF
// - function field encodes logic ops in transmit and edges in demodulation
//
// The implementer's own choice: the Wishbone interface to the registers.
`include "carrier_timer_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module dual_carrier_counter_timer
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:2] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic irq_capable_input_pin,
	input wire logic plain_input_pin,
	input wire logic port_value_shared,
	input wire logic port_value_wide,
	input wire logic port_value_narrow,
	output logic combined_output_pin,
	output logic wide_output_pin,
	output logic narrow_output_pin,
	output logic narrow_timeout_irq,
	output logic narrow_capture_irq,
	output logic wide_timeout_irq,
	output logic wide_capture_irq
);
	// ==========================================================
	// register state
	logic [7:0] narrow_ctrl_reg, shared_ctrl_reg, wide_ctrl_reg;
	logic sync_mode_reg;
	logic [7:0] narrow_low_hold_reg, narrow_high_hold_reg;
	logic [7:0] wide_hold_lower_reg, wide_hold_upper_reg;
	logic [7:0] narrow_cap_low_reg, narrow_cap_high_reg;
	logic [15:0] wide_cap_reg;
	logic narrow_en_reg, wide_en_reg, narrow_tout_reg, wide_tout_reg;
	logic rise_flag_reg, fall_flag_reg;
	logic [7:0] narrow_cnt_reg;
	logic [15:0] wide_cnt_reg;
	logic narrow_wave_out, wide_wave_out, narrow_run_reg, wide_run_reg;
	logic narrow_half_reg, wide_armed_reg;
	logic [2:0] presc_reg;
	logic [1:0] pin_meta_reg, pin_sync_reg;
	logic demod_in;
	logic filt_reg, filt_prev_reg;
	logic [3:0] filt_cnt_reg;
	logic ack_reg;
	logic wr, rd_ack;
	logic demod, sel;
	carrier_timer_pkg::submode_type submode;
	carrier_timer_pkg::combine_type combine_fn;
	carrier_timer_pkg::edge_type edge_sel;
	logic rise_pulse, fall_pulse, edge_pulse;
	logic narrow_tick, wide_tick;
	logic narrow_start, wide_start, narrow_stop_wr, wide_stop_wr;
	logic narrow_tc, wide_tc;
	logic narrow_capture, wide_capture, narrow_pp_done, wide_pp_done;
	logic narrow_flag_evt, wide_flag_evt, combined;
	logic [3:0] filt_len;
	logic [7:0] wdat;

	assign demod = shared_ctrl_reg[`BIT_MODE];
	assign sel = shared_ctrl_reg[`BIT_SEL];
	assign submode = carrier_timer_pkg::submode_type'(shared_ctrl_reg[`BIT_SUB_HI:`BIT_SUB_LO]);
	assign combine_fn = carrier_timer_pkg::combine_type'(shared_ctrl_reg[`BIT_FN_HI:`BIT_FN_LO]);
	assign edge_sel = carrier_timer_pkg::edge_type'(shared_ctrl_reg[`BIT_FN_HI:`BIT_FN_LO]);
	assign wdat = wb_dat_i[7:0];

	// ==========================================================
	// wishbone slave: one wait state, ack drops after one cycle
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !ack_reg;
	assign rd_ack = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wb_ack_o = ack_reg;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			ack_reg <= 1'b0;
		else
			ack_reg <= rd_ack;
	end

	// read mux, registered; unmapped offsets read zero
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			wb_dat_o <= 32'h00000000;
		else if (rd_ack)
		begin
			wb_dat_o <= 32'h00000000;
			case ({wb_adr_i, 2'b00})
				`OFS_NARROW_CTRL: wb_dat_o[7:0] <= {narrow_en_reg, narrow_ctrl_reg[6],
					narrow_tout_reg, narrow_ctrl_reg[4:0]};
				`OFS_SHARED_CTRL: wb_dat_o[7:0] <= demod ? {shared_ctrl_reg[7:2],
					rise_flag_reg, fall_flag_reg} : shared_ctrl_reg;
				`OFS_WIDE_CTRL: wb_dat_o[7:0] <= {wide_en_reg, wide_ctrl_reg[6],
					wide_tout_reg, wide_ctrl_reg[4:0]};
				`OFS_SYNC_CTRL: wb_dat_o[7:0] <= {wide_en_reg, narrow_en_reg, sync_mode_reg,
					`SYNC_RESERVED};
				`OFS_NARROW_LOW_HOLD: wb_dat_o[7:0] <= narrow_low_hold_reg;
				`OFS_NARROW_HIGH_HOLD: wb_dat_o[7:0] <= narrow_high_hold_reg;
				`OFS_WIDE_HOLD_LOWER: wb_dat_o[7:0] <= wide_hold_lower_reg;
				`OFS_WIDE_HOLD_UPPER: wb_dat_o[7:0] <= wide_hold_upper_reg;
				`OFS_WIDE_CAP_LOWER: wb_dat_o[7:0] <= wide_cap_reg[7:0];
				`OFS_WIDE_CAP_UPPER: wb_dat_o[7:0] <= wide_cap_reg[15:8];
				`OFS_NARROW_CAP_LOW: wb_dat_o[7:0] <= narrow_cap_low_reg;
				`OFS_NARROW_CAP_HIGH: wb_dat_o[7:0] <= narrow_cap_high_reg;
				default: wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	// plain control and hold registers
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			narrow_ctrl_reg <= `CTRL_RESET;
			shared_ctrl_reg <= `CTRL_RESET;
			wide_ctrl_reg <= `CTRL_RESET;
			sync_mode_reg <= 1'b0;
			narrow_low_hold_reg <= `HOLD_RESET;
			narrow_high_hold_reg <= `HOLD_RESET;
			wide_hold_lower_reg <= `HOLD_RESET;
			wide_hold_upper_reg <= `HOLD_RESET;
		end
		else if (wr)
		begin
			case ({wb_adr_i, 2'b00})
				`OFS_NARROW_CTRL: narrow_ctrl_reg <= wdat;
				`OFS_SHARED_CTRL: shared_ctrl_reg <= wdat;
				`OFS_WIDE_CTRL: wide_ctrl_reg <= wdat;
				`OFS_SYNC_CTRL: sync_mode_reg <= wdat[`BIT_SYNC_MODE];
				`OFS_NARROW_LOW_HOLD: narrow_low_hold_reg <= wdat;
				`OFS_NARROW_HIGH_HOLD: narrow_high_hold_reg <= wdat;
				`OFS_WIDE_HOLD_LOWER: wide_hold_lower_reg <= wdat;
				`OFS_WIDE_HOLD_UPPER: wide_hold_upper_reg <= wdat;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// input synchroniser, glitch filter and edge detector
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pin_meta_reg <= 2'b00;
			pin_sync_reg <= 2'b00;
		end
		else
		begin
			pin_meta_reg <= {plain_input_pin, irq_capable_input_pin};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// input choice made after both flops, so no raw pin reaches logic
	assign demod_in = sel ? pin_sync_reg[1] : pin_sync_reg[0];

	// filter: level must stay stable for filt_len cycles before it is accepted
	assign filt_len = (submode == carrier_timer_pkg::SUB_PINGPONG) ? `FILTER_SHORT :
		(submode == carrier_timer_pkg::SUB_FORCE_LOW) ? `FILTER_LONG : 4'h0;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			filt_reg <= 1'b0;
			filt_prev_reg <= 1'b0;
			filt_cnt_reg <= 4'h0;
		end
		else
		begin
			filt_prev_reg <= filt_reg;
			if (demod_in == filt_reg)
				filt_cnt_reg <= 4'h0;
			else if (filt_cnt_reg + 4'h1 >= filt_len)
			begin
				filt_reg <= demod_in;
				filt_cnt_reg <= 4'h0;
			end
			else
				filt_cnt_reg <= filt_cnt_reg + 4'h1;
		end
	end

	assign rise_pulse = demod && filt_reg && !filt_prev_reg &&
		(edge_sel == carrier_timer_pkg::EDGE_RISE || edge_sel == carrier_timer_pkg::EDGE_BOTH);
	assign fall_pulse = demod && !filt_reg && filt_prev_reg &&
		(edge_sel == carrier_timer_pkg::EDGE_FALL || edge_sel == carrier_timer_pkg::EDGE_BOTH);
	assign edge_pulse = rise_pulse || fall_pulse;

	// ==========================================================
	// prescaler: count ticks derived on core_clk, no divided clocks
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			presc_reg <= 3'h0;
		else
			presc_reg <= presc_reg + 3'h1;
	end

	function automatic logic tick_of(input logic [1:0] rate, input logic [2:0] p);
		tick_of = (rate == 2'b00) || (rate == 2'b01 && p[0]) ||
			(rate == 2'b10 && p[1:0] == 2'b11) || (rate == 2'b11 && p == 3'h7);
	endfunction

	assign narrow_tick = tick_of(narrow_ctrl_reg[`BIT_CLK_HI:`BIT_CLK_LO], presc_reg);
	assign wide_tick = tick_of(wide_ctrl_reg[`BIT_CLK_HI:`BIT_CLK_LO], presc_reg);

	// ==========================================================
	// enable control from either control register or sync register
	assign narrow_start = wr && wdat[`BIT_EN] && ({wb_adr_i, 2'b00} == `OFS_NARROW_CTRL) ||
		wr && wdat[`BIT_SYNC_NARROW_EN] && ({wb_adr_i, 2'b00} == `OFS_SYNC_CTRL);
	assign narrow_stop_wr = wr && !wdat[`BIT_EN] && ({wb_adr_i, 2'b00} == `OFS_NARROW_CTRL) ||
		wr && !wdat[`BIT_SYNC_NARROW_EN] && ({wb_adr_i, 2'b00} == `OFS_SYNC_CTRL);
	assign wide_start = wr && wdat[`BIT_EN] && ({wb_adr_i, 2'b00} == `OFS_WIDE_CTRL) ||
		wr && wdat[`BIT_SYNC_WIDE_EN] && ({wb_adr_i, 2'b00} == `OFS_SYNC_CTRL);
	assign wide_stop_wr = wr && !wdat[`BIT_EN] && ({wb_adr_i, 2'b00} == `OFS_WIDE_CTRL) ||
		wr && !wdat[`BIT_SYNC_WIDE_EN] && ({wb_adr_i, 2'b00} == `OFS_SYNC_CTRL);

	// terminal count is reaching 0 from 1; a start at 0 wraps without timeout
	assign narrow_tc = narrow_run_reg && narrow_tick && narrow_cnt_reg == 8'h01;
	assign wide_tc = wide_run_reg && wide_tick && wide_cnt_reg == 16'h0001;
	assign narrow_capture = demod && narrow_en_reg && narrow_run_reg && edge_pulse;
	assign wide_capture = demod && wide_en_reg && edge_pulse &&
		(!wide_ctrl_reg[`BIT_SINGLE] || wide_armed_reg);
	assign narrow_pp_done = !demod && submode == carrier_timer_pkg::SUB_PINGPONG &&
		narrow_tc && narrow_ctrl_reg[`BIT_SINGLE];
	assign wide_pp_done = !demod && submode == carrier_timer_pkg::SUB_PINGPONG &&
		wide_tc && wide_ctrl_reg[`BIT_SINGLE];
	assign narrow_flag_evt = narrow_tc && (demod || narrow_ctrl_reg[`BIT_SINGLE] ||
		narrow_half_reg);
	assign wide_flag_evt = wide_tc;

	// ==========================================================
	// narrow counter
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			narrow_en_reg <= 1'b0;
			narrow_run_reg <= 1'b0;
			narrow_cnt_reg <= 8'h00;
			narrow_wave_out <= 1'b1;
			narrow_half_reg <= 1'b0;
		end
		else if (narrow_start || wide_pp_done)
		begin
			narrow_en_reg <= 1'b1;
			narrow_half_reg <= 1'b0;
			narrow_run_reg <= !demod; // demodulation waits for first edge
			narrow_wave_out <= shared_ctrl_reg[`BIT_INIT8];
			narrow_cnt_reg <= demod ? `NARROW_FULL : (shared_ctrl_reg[`BIT_INIT8] ?
				narrow_high_hold_reg : narrow_low_hold_reg);
		end
		else if (narrow_stop_wr || !narrow_en_reg)
		begin
			narrow_en_reg <= 1'b0;
			narrow_run_reg <= 1'b0;
			narrow_wave_out <= !shared_ctrl_reg[`BIT_INIT8];
		end
		else if (demod && edge_pulse)
		begin
			narrow_run_reg <= 1'b1;
			narrow_cnt_reg <= `NARROW_FULL;
		end
		else if (narrow_tc && demod)
			narrow_cnt_reg <= 8'h00; // next tick wraps to FF and goes on
		else if (narrow_tc && narrow_ctrl_reg[`BIT_SINGLE])
		begin
			narrow_cnt_reg <= 8'h00;
			narrow_run_reg <= 1'b0;
			narrow_en_reg <= 1'b0;
			narrow_wave_out <= !narrow_wave_out;
		end
		else if (narrow_tc)
		begin
			narrow_half_reg <= !narrow_half_reg;
			narrow_wave_out <= !narrow_wave_out;
			narrow_cnt_reg <= narrow_wave_out ? narrow_low_hold_reg :
				narrow_high_hold_reg;
		end
		else if (narrow_run_reg && narrow_tick)
			narrow_cnt_reg <= narrow_cnt_reg - 8'h01;
	end

	// narrow capture registers, complemented count
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			narrow_cap_low_reg <= 8'h00;
			narrow_cap_high_reg <= 8'h00;
		end
		else if (narrow_capture && rise_pulse)
			narrow_cap_low_reg <= ~narrow_cnt_reg;
		else if (narrow_capture)
			narrow_cap_high_reg <= ~narrow_cnt_reg;
	end

	// ==========================================================
	// wide counter
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wide_en_reg <= 1'b0;
			wide_run_reg <= 1'b0;
			wide_armed_reg <= 1'b0;
			wide_cnt_reg <= 16'h0000;
			wide_wave_out <= 1'b1;
		end
		else if (wide_start || narrow_pp_done)
		begin
			wide_en_reg <= 1'b1;
			wide_armed_reg <= 1'b1;
			wide_run_reg <= !demod;
			wide_wave_out <= shared_ctrl_reg[`BIT_INIT16];
			wide_cnt_reg <= {wide_hold_upper_reg, wide_hold_lower_reg};
		end
		else if (wide_stop_wr || !wide_en_reg)
		begin
			wide_en_reg <= 1'b0;
			wide_run_reg <= 1'b0;
			wide_wave_out <= !shared_ctrl_reg[`BIT_INIT16];
		end
		else if (wide_capture)
		begin
			wide_run_reg <= 1'b1;
			wide_armed_reg <= 1'b0;
			wide_cnt_reg <= `WIDE_FULL;
		end
		else if (wide_tc && (demod || !wide_ctrl_reg[`BIT_SINGLE]))
		begin
			if (!demod)
				wide_wave_out <= !wide_wave_out;
			wide_cnt_reg <= demod ? 16'h0000 : {wide_hold_upper_reg,
				wide_hold_lower_reg};
		end
		else if (wide_tc)
		begin
			wide_cnt_reg <= 16'h0000;
			wide_run_reg <= 1'b0;
			wide_en_reg <= 1'b0;
			wide_wave_out <= !wide_wave_out;
		end
		else if (wide_run_reg && wide_tick)
			wide_cnt_reg <= wide_cnt_reg - 16'h0001;
	end

	// wide capture register
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			wide_cap_reg <= 16'h0000;
		else if (wide_capture && wide_run_reg)
			wide_cap_reg <= ~wide_cnt_reg;
	end

	// ==========================================================
	// sticky flags: hardware set wins over write-one clear
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			narrow_tout_reg <= 1'b0;
			wide_tout_reg <= 1'b0;
			rise_flag_reg <= 1'b0;
			fall_flag_reg <= 1'b0;
		end
		else
		begin
			if (narrow_flag_evt)
				narrow_tout_reg <= 1'b1;
			else if (wr && {wb_adr_i, 2'b00} == `OFS_NARROW_CTRL && wdat[`BIT_TOUT])
				narrow_tout_reg <= 1'b0;
			if (wide_flag_evt)
				wide_tout_reg <= 1'b1;
			else if (wr && {wb_adr_i, 2'b00} == `OFS_WIDE_CTRL && wdat[`BIT_TOUT])
				wide_tout_reg <= 1'b0;
			// edge flags follow every detected edge, also the one that starts counting
			if (rise_pulse)
				rise_flag_reg <= 1'b1;
			else if (wr && demod && {wb_adr_i, 2'b00} == `OFS_SHARED_CTRL && wdat[`BIT_INIT8])
				rise_flag_reg <= 1'b0;
			if (fall_pulse)
				fall_flag_reg <= 1'b1;
			else if (wr && demod && {wb_adr_i, 2'b00} == `OFS_SHARED_CTRL && wdat[`BIT_INIT16])
				fall_flag_reg <= 1'b0;
		end
	end

	// ==========================================================
	// outputs: combining, forcing and pin muxes, all registered
	always_comb
	begin
		case (combine_fn)
			carrier_timer_pkg::FN_AND: combined = narrow_wave_out & wide_eff();
			carrier_timer_pkg::FN_OR: combined = narrow_wave_out | wide_eff();
			carrier_timer_pkg::FN_NOR: combined = ~(narrow_wave_out | wide_eff());
			default: combined = ~(narrow_wave_out & wide_eff());
		endcase
	end

	// forced submodes override the wide output, enabled or not, in transmit only
	function automatic logic wide_eff();
		wide_eff = (!demod && submode == carrier_timer_pkg::SUB_FORCE_LOW) ? 1'b0 :
			(!demod && submode == carrier_timer_pkg::SUB_FORCE_HIGH) ? 1'b1 :
			wide_wave_out;
	endfunction

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			combined_output_pin <= 1'b0;
			wide_output_pin <= 1'b0;
			narrow_output_pin <= 1'b0;
			narrow_timeout_irq <= 1'b0;
			narrow_capture_irq <= 1'b0;
			wide_timeout_irq <= 1'b0;
			wide_capture_irq <= 1'b0;
		end
		else
		begin
			combined_output_pin <= (!demod && sel) ? combined : port_value_shared;
			wide_output_pin <= wide_ctrl_reg[`BIT_PIN_SEL] ? wide_eff() : port_value_wide;
			narrow_output_pin <= narrow_ctrl_reg[`BIT_PIN_SEL] ? narrow_wave_out : port_value_narrow;
			narrow_timeout_irq <= narrow_flag_evt && narrow_ctrl_reg[`BIT_TOUT_IE];
			narrow_capture_irq <= narrow_capture && narrow_run_reg && narrow_ctrl_reg[`BIT_CAP_IE];
			wide_timeout_irq <= wide_flag_evt && wide_ctrl_reg[`BIT_TOUT_IE];
			wide_capture_irq <= wide_capture && wide_ctrl_reg[`BIT_CAP_IE];
		end
	end

	// ==========================================================
	// checks
	AST_SYNC_RESERVED: assert property (@(posedge core_clk) disable iff (!rst_b)
		rd_ack && {wb_adr_i, 2'b00} == `OFS_SYNC_CTRL |=> wb_dat_o[4:0] == 5'h1F)
		else $error("reserved sync bits not ones");
	AST_NARROW_IDLE_LEVEL: assert property (@(posedge core_clk) disable iff (!rst_b)
		!wr && !narrow_en_reg && $stable(shared_ctrl_reg) && !narrow_start && !wide_pp_done
		|=> narrow_wave_out == !shared_ctrl_reg[`BIT_INIT8])
		else $error("narrow idle level wrong");
	AST_FORCE_LOW: assert property (@(posedge core_clk) disable iff (!rst_b)
		!demod && submode == carrier_timer_pkg::SUB_FORCE_LOW && wide_ctrl_reg[`BIT_PIN_SEL]
		&& $stable(shared_ctrl_reg) && $stable(wide_ctrl_reg) |=> !wide_output_pin)
		else $error("wide output not forced low");
	AST_WIDE_TOUT_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
		wide_tc |=> wide_tout_reg)
		else $error("wide timeout flag not set");
	AST_NARROW_LOAD: assert property (@(posedge core_clk) disable iff (!rst_b)
		narrow_start && !demod && !shared_ctrl_reg[`BIT_INIT8]
		|=> narrow_cnt_reg == $past(narrow_low_hold_reg))
		else $error("narrow low hold not loaded");
	AST_NARROW_SINGLE_STOP: assert property (@(posedge core_clk) disable iff (!rst_b)
		narrow_tc && !demod && narrow_ctrl_reg[`BIT_SINGLE] && !narrow_start && !wide_pp_done
		&& !narrow_stop_wr |=> !narrow_en_reg && narrow_wave_out != $past(narrow_wave_out))
		else $error("narrow single pass did not stop");
	AST_RISE_FLAG: assert property (@(posedge core_clk) disable iff (!rst_b)
		rise_pulse && narrow_capture |=> rise_flag_reg && narrow_cap_low_reg == ~$past(narrow_cnt_reg))
		else $error("rise capture wrong");
	AST_WIDE_RELOAD: assert property (@(posedge core_clk) disable iff (!rst_b)
		wide_tc && !demod && !wide_ctrl_reg[`BIT_SINGLE] && !wide_start && !narrow_pp_done
		&& !wide_stop_wr |=> wide_en_reg && wide_cnt_reg == {$past(wide_hold_upper_reg),
		$past(wide_hold_lower_reg)})
		else $error("wide did not reload");
	AST_ACK_PULSE: assert property (@(posedge core_clk) disable iff (!rst_b)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
endmodule
`default_nettype wire

// >>> testbench/carrier_pin_model.sv
// model of the carrier source that feeds the two measured input pins
`timescale 1ns/10ps
`default_nettype none
module carrier_pin_model
(
	input wire logic core_clk,
	input wire logic burst_level,
	output logic plain_input_pin,
	output logic irq_capable_input_pin
);
	// ==========
	// pin drive
	// the unused pin carries the opposite level so a wrong input choice shows
	always @(posedge core_clk)
	begin
		plain_input_pin <= burst_level;
		irq_capable_input_pin <= ~burst_level;
	end
endmodule
`default_nettype wire

// >>> testbench/test_dual_carrier_counter_timer.sv
// self-checking bench for the carrier counter/timer
`timescale 1ns/10ps
`default_nettype none
module test_dual_carrier_counter_timer;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, burst = 1'b0, saw_irq = 1'b0;
	logic saw_cirq = 1'b0, saw_wirq = 1'b0;
	logic [5:2] adr = 4'h0;
	logic [31:0] dat = 32'h0, rdat;
	logic [3:0] sel = 4'h0;
	logic ack, plain_pin, irq_pin, comb_pin, wide_pin, narrow_pin, n_tirq, n_cirq, w_tirq;
	logic [7:0] q;
	int error_cnt = 0, check_count = 0, cycles = 0, n, k;
	always #2 core_clk = ~core_clk;
	// ==========
	// design and carrier source
	dual_carrier_counter_timer dut_u (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
		.wb_dat_o(rdat), .wb_ack_o(ack), .irq_capable_input_pin(irq_pin),
		.plain_input_pin(plain_pin), .port_value_shared(1'b1), .port_value_wide(1'b1),
		.port_value_narrow(1'b1), .combined_output_pin(comb_pin), .wide_output_pin(wide_pin),
		.narrow_output_pin(narrow_pin), .narrow_timeout_irq(n_tirq), .narrow_capture_irq(n_cirq),
		.wide_timeout_irq(w_tirq), .wide_capture_irq());
	carrier_pin_model model_u (.core_clk(core_clk), .burst_level(burst),
		.plain_input_pin(plain_pin), .irq_capable_input_pin(irq_pin));
	// ==========
	// run limit and sticky monitors
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (n_cirq === 1'b1) saw_cirq <= 1'b1;
		if (w_tirq === 1'b1) saw_wirq <= 1'b1;
		if (n_tirq === 1'b1) saw_irq <= 1'b1;
		if (cycles == 20000)
		begin
			error_cnt = error_cnt + 1;
			test_done();
		end
	end
	// ==========
	// tasks
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count = check_count + 1;
		if (seen !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one classic wishbone cycle, held until ack is sampled high
	task automatic bus(input logic w, input logic [5:0] ofs, input logic [7:0] d);
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ofs[5:2];
		dat <= {24'h0, d};
		sel <= 4'hF;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n = n + 1;
		end while (ack !== 1'b1 && n < 50);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50) check("ack", 8'h00, 8'h01);
	endtask
	task automatic settle();
		repeat (5) @(posedge core_clk);
	endtask
	// ==========
	// scenarios
	initial
	begin
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		bus(0, 6'h0C, 8'h00); check("sync reset", q, 8'h1F);
		check("port route", {7'h0, comb_pin}, 8'h01);
		bus(1, 6'h0C, 8'h20); bus(0, 6'h0C, 8'h00); check("sync bit", q, 8'h3F);
		bus(0, 6'h30, 8'h00); check("unmapped", q, 8'h00);
		bus(1, 6'h0C, 8'h00);
		bus(1, 6'h00, 8'h01);
		bus(1, 6'h08, 8'h01);
		for (int f = 0; f < 4; f++)
		begin
			bus(1, 6'h04, 8'h42 | (8'(f) << 4)); settle();
			check("narrow idle", {7'h0, narrow_pin}, 8'h00);
			check("wide idle", {7'h0, wide_pin}, 8'h01);
			check("combined", {7'h0, comb_pin}, {7'h0, f[0]});
		end
		bus(1, 6'h04, 8'h48); settle(); check("force low", {7'h0, wide_pin}, 8'h00);
		bus(1, 6'h04, 8'h4C); settle(); check("force high", {7'h0, wide_pin}, 8'h01);
		bus(1, 6'h04, 8'h42);
		bus(1, 6'h10, 8'h03);
		bus(1, 6'h14, 8'h05);
		bus(1, 6'h00, 8'hC3);
		@(posedge core_clk); check("started high", {7'h0, narrow_pin}, 8'h01);
		k = 0;
		do
		begin
			bus(0, 6'h00, 8'h00);
			k = k + 1;
		end while (q[5] !== 1'b1 && k < 100);
		settle();
		check("timeout", q & 8'h20, 8'h20);
		check("toggled", {7'h0, narrow_pin}, 8'h00);
		check("irq", {7'h0, saw_irq}, 8'h01);
		bus(1, 6'h00, 8'h03); bus(0, 6'h00, 8'h00); check("w0", q & 8'h20, 8'h20);
		bus(1, 6'h00, 8'h23); bus(0, 6'h00, 8'h00); check("w1c", q & 8'h20, 8'h00);
		// narrow modulo-N from level 0, then stop and clear in two writes
		bus(1, 6'h04, 8'h40); bus(1, 6'h00, 8'h83); repeat (40) @(posedge core_clk);
		bus(0, 6'h00, 8'h00); check("narrow modulo", q & 8'hA0, 8'hA0);
		bus(1, 6'h00, 8'h03); bus(1, 6'h00, 8'h23);
		bus(0, 6'h00, 8'h00); check("narrow stopped", q & 8'hA0, 8'h00);
		// wide counter at an eighth of the clock, modulo-N then single-pass
		bus(1, 6'h18, 8'h03); bus(1, 6'h08, 8'h9B); repeat (100) @(posedge core_clk);
		bus(0, 6'h08, 8'h00); check("wide modulo", q & 8'hA0, 8'hA0);
		bus(1, 6'h08, 8'h1B); bus(1, 6'h08, 8'h3B);
		bus(0, 6'h08, 8'h00); check("wide w1c", q & 8'hA0, 8'h00);
		bus(1, 6'h08, 8'hDB); repeat (100) @(posedge core_clk);
		bus(0, 6'h08, 8'h00); check("wide single", q & 8'hA0, 8'h20);
		check("wide irq", {7'h0, saw_wirq}, 8'h01);
		// demodulation on the plain pin, narrow counter measuring
		bus(1, 6'h10, 8'hFF); bus(1, 6'h14, 8'hFF);
		bus(1, 6'h04, 8'hE0); bus(1, 6'h00, 8'h84);
		burst <= 1'b1; repeat (12) @(posedge core_clk);
		bus(0, 6'h04, 8'h00); check("rise", q & 8'h03, 8'h02);
		burst <= 1'b0; repeat (12) @(posedge core_clk);
		bus(0, 6'h04, 8'h00); check("fall", q & 8'h03, 8'h03);
		bus(1, 6'h04, 8'hE2); bus(0, 6'h04, 8'h00); check("clr rise", q & 8'h03, 8'h01);
		bus(1, 6'h04, 8'hE1); bus(0, 6'h04, 8'h00); check("clr fall", q & 8'h03, 8'h00);
		burst <= 1'b1; repeat (12) @(posedge core_clk);
		check("capture irq", {7'h0, saw_cirq}, 8'h01);
		test_done();
	end
endmodule
`default_nettype wire
